//--- core/cas_core.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cas_core (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        wdt_timeout,
   output logic [12:0]      prog_addr,
   output logic [8:0]       data_addr,
   output logic             data_wr,
   output logic [7:0]       data_wdata,
   output logic             stack_push,
   output logic             stack_pop,
   output logic [1:0]       phase
);

   // ************************************************************
   // Reset release and phase sequencer
   // ************************************************************
   logic       rst_m_q, rst_q;
   cas_pkg::cas_phase_e ph_q, ph_d;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_m_q <= 1'b0;
         rst_q   <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_q   <= rst_m_q;
      end
   end

   always_comb begin
      unique case (ph_q)
         cas_pkg::PH_DECODE:  ph_d = cas_pkg::PH_READ;
         cas_pkg::PH_READ:    ph_d = cas_pkg::PH_PROCESS;
         cas_pkg::PH_PROCESS: ph_d = cas_pkg::PH_WRITE;
         cas_pkg::PH_WRITE:   ph_d = cas_pkg::PH_DECODE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) ph_q <= cas_pkg::PH_DECODE;
      else        ph_q <= ph_d;
   end
   assign phase = ph_q;

   // ************************************************************
   // Register bus slave
   // ************************************************************
   logic [13:0] instr_q;
   logic [7:0]  fdata_q, wreg_q, result_q, status_q;
   logic        run_q, aw_q, w_q;
   logic [7:0]  awa_q;
   logic [31:0] wd_q;
   logic [3:0]  wstrb_q;

   wire do_wr = aw_q && w_q && !bvalid;
   wire wr_instr = do_wr && awa_q == cas_pkg::ADDR_INSTR;
   wire wr_fdata = do_wr && awa_q == cas_pkg::ADDR_FDATA;
   wire wr_ctrl  = do_wr && awa_q == cas_pkg::ADDR_CTRL;
   wire wr_known = wr_instr || wr_fdata || wr_ctrl;
   assign awready = !aw_q && !bvalid;
   assign wready  = !w_q && !bvalid;
   assign arready = !rvalid;

   wire ra_ok = araddr == cas_pkg::ADDR_INSTR || araddr == cas_pkg::ADDR_FDATA ||
                araddr == cas_pkg::ADDR_STATUS || araddr == cas_pkg::ADDR_WREG ||
                araddr == cas_pkg::ADDR_RESULT || araddr == cas_pkg::ADDR_CTRL;
   logic [31:0] rsel;
   always_comb begin
      rsel = 32'h0;
      if (araddr == cas_pkg::ADDR_INSTR)  rsel = {18'h0, instr_q};
      if (araddr == cas_pkg::ADDR_FDATA)  rsel = {24'h0, fdata_q};
      if (araddr == cas_pkg::ADDR_STATUS) rsel = {24'h0, status_q};
      if (araddr == cas_pkg::ADDR_WREG)   rsel = {24'h0, wreg_q};
      if (araddr == cas_pkg::ADDR_RESULT) rsel = {24'h0, result_q};
      if (araddr == cas_pkg::ADDR_CTRL)   rsel = {31'h0, run_q};
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h0; wd_q <= 32'h0;
         bvalid <= 1'b0; bresp <= 2'h0; rvalid <= 1'b0; rresp <= 2'h0; rdata <= 32'h0;
      end else begin
         if (awvalid && awready) begin aw_q <= 1'b1; awa_q <= awaddr; end
         if (wvalid && wready) begin w_q <= 1'b1; wd_q <= wdata; end
         if (do_wr) begin
            aw_q <= 1'b0; w_q <= 1'b0; bvalid <= 1'b1;
            bresp <= wr_known ? cas_pkg::RESP_OKAY : cas_pkg::RESP_SLVERR;
         end else if (bvalid && bready) bvalid <= 1'b0;
         if (arvalid && arready) begin
            rvalid <= 1'b1; rdata <= rsel;
            rresp <= ra_ok ? cas_pkg::RESP_OKAY : cas_pkg::RESP_SLVERR;
         end else if (rvalid && rready) rvalid <= 1'b0;
      end
   end

   // Strobes gate byte lanes so partial writes do not corrupt upper bits.
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         instr_q <= 14'h0; fdata_q <= 8'h0; run_q <= 1'b0;
      end else begin
         if (wr_instr && wstrb_q[0]) instr_q[7:0] <= wd_q[7:0];
         if (wr_instr && wstrb_q[1]) instr_q[13:8] <= wd_q[13:8];
         if (wr_fdata && wstrb_q[0]) fdata_q <= wd_q[7:0];
         if (wr_ctrl && wstrb_q[0]) run_q <= wd_q[0];
      end
   end
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) wstrb_q <= 4'h0;
      else if (wvalid && wready) wstrb_q <= wstrb;
   end

   // ************************************************************
   // Decode by format
   // ************************************************************
   cas_pkg::cas_op_e op_q;
   cas_pkg::cas_op_e op_dec;
   logic sleep_op, watchdog_clear_instruction_op, retfie_op;
   wire [1:0] fmt  = instr_q[13:12];
   wire [3:0] sub4 = instr_q[11:8];
   wire       dbit = instr_q[7];
   wire [2:0] bsel = instr_q[9:7];
   wire [7:0] lit  = instr_q[7:0];
   always_comb begin
      op_dec = cas_pkg::OP_NOP; sleep_op = 1'b0; watchdog_clear_instruction_op = 1'b0; retfie_op = 1'b0;
      unique case (fmt)
         2'b00: begin
            unique case (sub4)
               4'h0: begin
                  if (dbit) op_dec = cas_pkg::OP_MOVE_TO_FILE_INSTRUCTION;
                  else if (lit == 8'h08) op_dec = cas_pkg::OP_RETURN;
                  else if (lit == 8'h09) retfie_op = 1'b1;
                  else if (lit == 8'h63) sleep_op = 1'b1;
                  else if (lit == 8'h64) watchdog_clear_instruction_op = 1'b1;
               end
               4'h1: op_dec = dbit ? cas_pkg::OP_CLEAR_FILE_INSTRUCTION : cas_pkg::OP_CLRW;
               default: op_dec = cas_pkg::cas_op_e'({1'b0, sub4} + 5'h2);
            endcase
            if (sub4 == 4'he) op_dec = cas_pkg::OP_NIBBLE_SWAP_INSTRUCTION;
            if (sub4 == 4'hf) op_dec = cas_pkg::OP_INCFSZ;
         end
         2'b01: op_dec = cas_pkg::cas_op_e'(5'h12 + {3'b000, instr_q[11:10]});
         2'b10: op_dec = instr_q[11] ? cas_pkg::OP_GOTO : cas_pkg::OP_CALL;
         2'b11: begin
            unique casez (sub4)
               4'b00??: op_dec = cas_pkg::OP_MOVLW;
               4'b01??: op_dec = cas_pkg::OP_RETLW;
               4'b1000: op_dec = cas_pkg::OP_IORLW;
               4'b1001: op_dec = cas_pkg::OP_ANDLW;
               4'b1010: op_dec = cas_pkg::OP_XORLW;
               4'b110?: op_dec = cas_pkg::OP_SUBLW;
               4'b111?: op_dec = cas_pkg::OP_ADDLW;
               default: op_dec = cas_pkg::OP_NOP;
            endcase
         end
      endcase
   end

   // ************************************************************
   // ALU
   // ************************************************************
   logic [7:0] opnd_q;
   cas_pkg::cas_alu_s alu;
   wire lit_op = fmt == 2'b11;
   wire [7:0] src = lit_op ? lit : opnd_q;
   wire c_in = status_q[cas_pkg::STAT_CARRY];
   wire [8:0] sum   = {1'b0, src} + {1'b0, wreg_q};
   wire [8:0] diff  = {1'b0, src} + {1'b0, ~wreg_q} + 9'h1;
   wire [4:0] sum_l = {1'b0, src[3:0]} + {1'b0, wreg_q[3:0]};
   wire [4:0] dif_l = {1'b0, src[3:0]} + {1'b0, ~wreg_q[3:0]} + 5'h1;
   wire [7:0] bmask = 8'h01 << bsel;
   logic upd_cdc, upd_c, upd_z;
   always_comb begin
      alu = '0; upd_cdc = 1'b0; upd_c = 1'b0; upd_z = 1'b1;
      alu.wr_file = dbit; alu.wr_w = !dbit;
      unique case (op_q)
         cas_pkg::OP_ADDWF, cas_pkg::OP_ADDLW: begin
            alu.result = sum[7:0]; alu.carry = sum[8]; alu.digit = sum_l[4]; upd_cdc = 1'b1;
         end
         cas_pkg::OP_SUBWF, cas_pkg::OP_SUBLW: begin
            alu.result = diff[7:0]; alu.carry = diff[8]; alu.digit = dif_l[4]; upd_cdc = 1'b1;
         end
         cas_pkg::OP_ANDWF, cas_pkg::OP_ANDLW: alu.result = src & wreg_q;
         cas_pkg::OP_IORWF, cas_pkg::OP_IORLW: alu.result = src | wreg_q;
         cas_pkg::OP_XORWF, cas_pkg::OP_XORLW: alu.result = src ^ wreg_q;
         cas_pkg::OP_COMF:  alu.result = ~src;
         cas_pkg::OP_INCF:  alu.result = src + 8'h1;
         cas_pkg::OP_DECF:  alu.result = src - 8'h1;
         cas_pkg::OP_MOVF:  alu.result = src;
         cas_pkg::OP_CLRW:  begin alu.result = 8'h0; alu.wr_w = 1'b1; alu.wr_file = 1'b0; end
         cas_pkg::OP_CLEAR_FILE_INSTRUCTION:  begin alu.result = 8'h0; alu.wr_w = 1'b0; alu.wr_file = 1'b1; end
         cas_pkg::OP_RLF:   begin alu.result = {src[6:0], c_in}; alu.carry = src[7]; upd_c = 1'b1; upd_z = 1'b0; end
         cas_pkg::OP_RRF:   begin alu.result = {c_in, src[7:1]}; alu.carry = src[0]; upd_c = 1'b1; upd_z = 1'b0; end
         default: upd_z = 1'b0;
      endcase
      if (op_q == cas_pkg::OP_NIBBLE_SWAP_INSTRUCTION) alu.result = {src[3:0], src[7:4]};
      if (op_q == cas_pkg::OP_MOVE_TO_FILE_INSTRUCTION) begin alu.result = wreg_q; alu.wr_file = 1'b1; alu.wr_w = 1'b0; end
      if (op_q == cas_pkg::OP_BCF || op_q == cas_pkg::OP_BSF) begin
         alu.result = op_q == cas_pkg::OP_BSF ? (src | bmask) : (src & ~bmask);
         alu.wr_file = 1'b1; alu.wr_w = 1'b0;
      end
      if (lit_op) begin
         alu.wr_file = 1'b0;
         alu.wr_w = op_q != cas_pkg::OP_NOP;
         if (op_q == cas_pkg::OP_MOVLW || op_q == cas_pkg::OP_RETLW) alu.result = lit;
      end
      if (op_q == cas_pkg::OP_NOP || op_q == cas_pkg::OP_GOTO || op_q == cas_pkg::OP_CALL ||
          op_q == cas_pkg::OP_RETURN || op_q == cas_pkg::OP_BTFSC || op_q == cas_pkg::OP_BTFSS) begin
         alu.wr_file = 1'b0; alu.wr_w = 1'b0;
      end
      alu.zero = alu.result == 8'h00;
   end

   // ************************************************************
   // Status, W and data paths across the phases
   // ************************************************************
   logic sleep_q, watchdog_clear_instruction_q, go_q;
   wire to_status = alu.wr_file && instr_q[6:0] == cas_pkg::STATUS_FILE_ADDR;
   wire exec = go_q && ph_q == cas_pkg::PH_WRITE;
   logic [7:0] stat_d;
   always_comb begin
      stat_d = status_q;
      if (exec && to_status) stat_d = {alu.result[7:5], status_q[4:3],
                                       (upd_z || upd_cdc || upd_c) ? status_q[2:0] : alu.result[2:0]};
      if (exec && upd_z) stat_d[cas_pkg::STAT_ZERO] = alu.zero;
      if (exec && upd_cdc) begin
         stat_d[cas_pkg::STAT_CARRY] = alu.carry;
         stat_d[cas_pkg::STAT_DIGIT] = alu.digit;
      end
      if (exec && upd_c) stat_d[cas_pkg::STAT_CARRY] = alu.carry;
      if (exec && watchdog_clear_instruction_q) stat_d[4:3] = 2'b11;
      if (exec && sleep_q) stat_d[4:3] = 2'b10;
      if (wdt_timeout) stat_d[cas_pkg::STAT_TIMEOUT] = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         op_q <= cas_pkg::OP_NOP; opnd_q <= 8'h0; go_q <= 1'b0; sleep_q <= 1'b0; watchdog_clear_instruction_q <= 1'b0;
         wreg_q <= 8'h0; result_q <= 8'h0; status_q <= cas_pkg::STATUS_RESET;
         prog_addr <= 13'h0; data_wr <= 1'b0; data_wdata <= 8'h0;
      end else begin
         status_q <= stat_d;
         data_wr <= 1'b0;
         if (ph_q == cas_pkg::PH_DECODE) begin
            go_q <= run_q;
            op_q <= run_q ? op_dec : cas_pkg::OP_NOP;
            sleep_q <= run_q && sleep_op; watchdog_clear_instruction_q <= run_q && watchdog_clear_instruction_op;
         end
         if (ph_q == cas_pkg::PH_READ) opnd_q <= fdata_q;
         if (exec) begin
            result_q <= alu.result;
            if (alu.wr_w) wreg_q <= alu.result;
            data_wr <= alu.wr_file && !to_status;
            data_wdata <= alu.result;
            prog_addr <= op_q == cas_pkg::OP_GOTO || op_q == cas_pkg::OP_CALL ?
                         {2'b00, instr_q[10:0]} : prog_addr + 13'h1;
         end
      end
   end

   // The indirect bit is not used here; direct bits RP1:RP0 pick a 128-byte bank.
   assign data_addr  = {status_q[cas_pkg::STAT_RP_HIGH:cas_pkg::STAT_RP_LOW], instr_q[6:0]};
   assign stack_push = exec && op_q == cas_pkg::OP_CALL;
   logic retfie_q;
   assign stack_pop  = exec && (op_q == cas_pkg::OP_RETURN || op_q == cas_pkg::OP_RETLW || retfie_q);
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) retfie_q <= 1'b0;
      else if (ph_q == cas_pkg::PH_DECODE) retfie_q <= run_q && retfie_op;
   end
   wire ibank = status_q[cas_pkg::STAT_IBANK];

   // ************************************************************
   // Checks
   // ************************************************************
   AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!rst_q)
      ph_q == cas_pkg::PH_DECODE |=> ph_q == cas_pkg::PH_READ ##1 ph_q == cas_pkg::PH_PROCESS
      ##1 ph_q == cas_pkg::PH_WRITE ##1 ph_q == cas_pkg::PH_DECODE) else $error("phase order broken");
   AST_WR_PHASE: assert property (@(posedge clk) disable iff (!rst_q)
      data_wr |-> $past(ph_q) == cas_pkg::PH_WRITE) else $error("data write outside write phase");
   AST_RO_FLAGS: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && to_status && !watchdog_clear_instruction_q && !sleep_q && !wdt_timeout) |=> $stable(status_q[4:3]))
      else $error("read-only flags changed");
   AST_ZERO: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && upd_z) |=> status_q[cas_pkg::STAT_ZERO] == (result_q == 8'h00)) else $error("zero flag wrong");
   AST_CLEAR_FILE_INSTRUCTION_STATUS: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && op_q == cas_pkg::OP_CLEAR_FILE_INSTRUCTION && to_status) |=> status_q[7:5] == 3'b000
      && status_q[cas_pkg::STAT_ZERO]) else $error("clear of status wrong");
   AST_SUB_BORROW: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && (op_q == cas_pkg::OP_SUBWF || op_q == cas_pkg::OP_SUBLW))
      |=> status_q[cas_pkg::STAT_CARRY] == ($past(src) >= $past(wreg_q))) else $error("borrow wrong");
   AST_SLEEP: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && sleep_q && !wdt_timeout) |=> status_q[4:3] == 2'b10) else $error("sleep flags wrong");
   AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_q)
      wdt_timeout |=> !status_q[cas_pkg::STAT_TIMEOUT]) else $error("timeout flag not cleared");
   AST_STATUS_NOMEM: assert property (@(posedge clk) disable iff (!rst_q)
      (exec && to_status) |=> !data_wr) else $error("status write went to memory");

endmodule
`default_nettype wire

//--- core/cas_pkg.sv
package cas_pkg;

   // ************************************************************
   // Status register layout
   // ************************************************************
   localparam int STAT_CARRY     = 0;
   localparam int STAT_DIGIT     = 1;
   localparam int STAT_ZERO      = 2;
   localparam int STAT_PDOWN     = 3;
   localparam int STAT_TIMEOUT   = 4;
   localparam int STAT_RP_LOW    = 5;
   localparam int STAT_RP_HIGH   = 6;
   localparam int STAT_IBANK     = 7;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [6:0] STATUS_FILE_ADDR = 7'h03;

   // ************************************************************
   // Register bus map
   // ************************************************************
   localparam logic [7:0] ADDR_INSTR  = 8'h00;
   localparam logic [7:0] ADDR_FDATA  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WREG   = 8'h0c;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_CTRL   = 8'h14;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // Execution types
   // ************************************************************
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } cas_phase_e;

   typedef enum logic [4:0] {
      OP_NOP  = 5'h00, OP_MOVE_TO_FILE_INSTRUCTION = 5'h01, OP_CLEAR_FILE_INSTRUCTION  = 5'h02, OP_CLRW  = 5'h03,
      OP_SUBWF= 5'h04, OP_DECF  = 5'h05, OP_IORWF = 5'h06, OP_ANDWF = 5'h07,
      OP_XORWF= 5'h08, OP_ADDWF = 5'h09, OP_MOVF  = 5'h0a, OP_COMF  = 5'h0b,
      OP_INCF = 5'h0c, OP_DECFSZ= 5'h0d, OP_RRF   = 5'h0e, OP_RLF   = 5'h0f,
      OP_NIBBLE_SWAP_INSTRUCTION= 5'h10, OP_INCFSZ= 5'h11, OP_BCF   = 5'h12, OP_BSF   = 5'h13,
      OP_BTFSC= 5'h14, OP_BTFSS = 5'h15, OP_MOVLW = 5'h16, OP_RETLW = 5'h17,
      OP_IORLW= 5'h18, OP_ANDLW = 5'h19, OP_XORLW = 5'h1a, OP_SUBLW = 5'h1b,
      OP_ADDLW= 5'h1c, OP_CALL  = 5'h1d, OP_GOTO  = 5'h1e, OP_RETURN= 5'h1f
   } cas_op_e;

   typedef struct packed {
      logic [7:0] result;
      logic       carry;
      logic       digit;
      logic       zero;
      logic       wr_file;
      logic       wr_w;
   } cas_alu_s;

endpackage

//--- verif/cas_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// File memory and return-stack push and pop counters on the far side of the core.
// ************************************************************
module cas_mem_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [8:0] data_addr,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wdata,
   input  wire logic       stack_push,
   input  wire logic       stack_pop,
   output logic [7:0]      last_wdata,
   output logic [8:0]      last_waddr,
   output var int          pushes,
   output var int          pops
);
   logic [7:0] file_mem [512];

   // Only the last write is kept visible, since the core never reads back from here.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_wdata <= 8'h00;
         last_waddr <= 9'h000;
         pushes     <= 0;
         pops       <= 0;
      end else begin
         if (data_wr) begin
            file_mem[data_addr] <= data_wdata;
            last_wdata          <= data_wdata;
            last_waddr          <= data_addr;
         end
         if (stack_push) pushes <= pushes + 1;
         if (stack_pop) pops <= pops + 1;
      end
   end
endmodule
`default_nettype wire

//--- verif/test_cpu_alu_status_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_alu_status_core;
   logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, wdt_timeout;
   logic        awready, wready, bvalid, arready, rvalid, data_wr, stack_push, stack_pop;
   logic [7:0]  awaddr, araddr, data_wdata, last_wdata, m_st, m_w, k, fv;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, phase, resp;
   logic [12:0] prog_addr;
   logic [8:0]  data_addr, last_waddr;
   logic [6:0]  fa;
   logic [10:0] mr;
   logic [15:0] lfsr;
   logic [3:0]  ops [8] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h9, 4'ha, 4'h3};
   int          n_errors, compares, cyc, pushes, pops;

   cas_core u_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .wdt_timeout(wdt_timeout), .prog_addr(prog_addr),
      .data_addr(data_addr), .data_wr(data_wr), .data_wdata(data_wdata), .stack_push(stack_push),
      .stack_pop(stack_pop), .phase(phase));
   cas_mem_model u_mem (.clk(clk), .rstn(rstn), .data_addr(data_addr), .data_wr(data_wr),
      .data_wdata(data_wdata), .stack_push(stack_push), .stack_pop(stack_pop), .last_wdata(last_wdata),
      .last_waddr(last_waddr), .pushes(pushes), .pops(pops));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic test_done;
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Returns result, zero, digit carry and carry; flags not touched pass through.
   function automatic logic [10:0] model(input logic [3:0] op, input logic [7:0] w, input logic [7:0] f,
                                         input logic [7:0] st);
      int   r;
      logic c, dc;
      c = st[0];
      dc = st[1];
      case (op)
         4'h7: begin
            r = w + f;
            c = r > 255;
            dc = (w % 16 + f % 16) > 15;
         end
         4'h2: begin
            r = f - w;
            c = f >= w;
            dc = (f % 16) >= (w % 16);
         end
         4'h5: r = w & f;
         4'h4: r = w | f;
         4'h6: r = w ^ f;
         4'h9: r = ~f;
         4'ha: r = f + 1;
         default: r = f - 1;
      endcase
      return {8'(r), 8'(r) == 8'h00, dc, c};
   endfunction

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done) begin
         @(posedge clk);
         done = bvalid;
         resp = bresp;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done) begin
         @(posedge clk);
         done = rvalid;
         rd = rdata;
         resp = rresp;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   // Every instruction used here gives the same outcome when repeated, so the run window may span several cycles.
   task automatic exec(input logic [13:0] ins, input logic [7:0] f);
      axw(cas_pkg::ADDR_FDATA, {24'h0, f});
      axw(cas_pkg::ADDR_INSTR, {18'h0, ins});
      axw(cas_pkg::ADDR_CTRL, 32'h1);
      repeat (12) @(posedge clk);
      axw(cas_pkg::ADDR_CTRL, 32'h0);
   endtask

   task automatic jump(input logic [13:0] ins, input logic [10:0] tgt);
      logic       seen;
      logic [1:0] p;
      seen = 1'b0;
      axw(cas_pkg::ADDR_INSTR, {18'h0, ins});
      axw(cas_pkg::ADDR_CTRL, 32'h1);
      for (int c = 0; c < 12; c++) begin
         @(negedge clk);
         if (c > 0) chk(32'(phase), 32'(2'(p + 2'd1)));
         if (stack_push || stack_pop) chk(32'(phase), 32'h3);
         if (prog_addr[10:0] === tgt) seen = 1'b1;
         p = phase;
      end
      axw(cas_pkg::ADDR_CTRL, 32'h0);
      chk(32'(seen), 32'h1);
   endtask

   task automatic rdst;
      axr(cas_pkg::ADDR_STATUS);
      chk(rd, {24'h0, m_st});
   endtask

   // ************************************************************
   // Clock, reset, timeout and scenarios
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         test_done;
      end
   end

   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, wdt_timeout} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      lfsr = 16'h0004;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      m_st = cas_pkg::STATUS_RESET;
      rdst();
      axw(cas_pkg::ADDR_STATUS, 32'hff);
      rdst();
      axr(cas_pkg::ADDR_WREG);
      m_w = rd[7:0];
      axw(cas_pkg::ADDR_WREG, {24'h0, ~m_w});
      axr(cas_pkg::ADDR_WREG);
      chk(rd, {24'h0, m_w});
      axr(8'h40);
      chk({rd[29:0], resp}, {30'h0, cas_pkg::RESP_SLVERR});
      axw(8'h44, 32'h1);
      chk(32'(resp), 32'(cas_pkg::RESP_SLVERR));
      for (int i = 0; i < 2; i++) begin
         k = i ? 8'he7 : 8'he0;
         exec(14'h3000 | 14'(k), 8'h00);
         exec(14'h0083, 8'h00);
         m_st = (k & 8'he7) | (m_st & 8'h18);
         rdst();
      end
      for (int i = 0; i < 24; i++) begin
         lfsr = nxt(lfsr);
         k = lfsr[7:0];
         lfsr = nxt(lfsr);
         fv = lfsr[7:0];
         fa = {2'b01, lfsr[12:8]};
         if (i < 2) {k, fv} = 16'h8888;
         exec(14'h3000 | 14'(k), 8'h00);
         m_w = k;
         exec({2'b00, ops[i % 8], 1'b1, fa}, fv);
         mr = model(ops[i % 8], m_w, fv, m_st);
         m_st[2:0] = mr[2:0];
         chk(32'(data_addr), 32'({m_st[6:5], fa}));
         chk({last_waddr, last_wdata}, {m_st[6:5], fa, mr[10:3]});
         axr(cas_pkg::ADDR_RESULT);
         chk(rd, {24'h0, mr[10:3]});
         axr(cas_pkg::ADDR_WREG);
         chk(rd, {24'h0, m_w});
         rdst();
      end
      exec(14'h3000, 8'h00);
      exec(14'h0583, 8'h5a);
      m_st = {3'b000, m_st[4:3], 1'b1, m_st[1:0]};
      rdst();
      exec(14'h30ff, 8'h00);
      exec(14'h0083, 8'h00);
      exec(14'h0183, 8'h00);
      m_st = {3'b000, m_st[4:3], 3'b111};
      rdst();
      exec(14'h1683, m_st);
      exec(14'h1003, m_st | 8'h20);
      m_st = (m_st | 8'h20) & 8'hfe;
      rdst();
      @(posedge clk);
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      m_st[4] = 1'b0;
      rdst();
      exec(14'h0064, 8'h00);
      m_st[4:3] = 2'b11;
      rdst();
      exec(14'h0063, 8'h00);
      m_st[4:3] = 2'b10;
      rdst();
      jump(14'h2955, 11'h155);
      jump(14'h20aa, 11'h0aa);
      jump(14'h0008, 11'h0ab);
      chk(32'(pushes > 0 && pops > 0), 32'h1);
      test_done;
   end
endmodule
`default_nettype wire
